// File: rtl/rlwg_defines.svh
/*
 * Constants of the raw lane width gearing block: bus widths, FIFO depth,
 * deskew depth and link timing.
 * Assumes it is included by bare name before the block's package and modules.
 */
`ifndef RLWG_DEFINES_SVH
`define RLWG_DEFINES_SVH

`define RLWG_BUS_W 40
`define RLWG_PMA_W 20
`define RLWG_FIFO_DEPTH 32
`define RLWG_DSK_STAGES 3
`define RLWG_SYS_PERIOD_NS 10
`define RLWG_LINK_PERIOD_NS 80
`define RLWG_LINK_CYC (`RLWG_LINK_PERIOD_NS / `RLWG_SYS_PERIOD_NS)

`endif

// File: rtl/rlwg_pkg.sv
/*
 * Types of the raw lane width gearing block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package rlwg_pkg;

    // medium width, internal width and gearing of each documented mode
    typedef enum logic [3:0] {
        RLWG_M1A, RLWG_M1B,
        RLWG_M2A, RLWG_M2B, RLWG_M2C, RLWG_M2D,
        RLWG_M3A, RLWG_M3B,
        RLWG_M4A, RLWG_M4B,
        RLWG_M5A, RLWG_M5B
    } rlwg_mode_t;

endpackage : rlwg_pkg

`default_nettype wire

// File: rtl/rlwg_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a flop-array store.
 * Assumes both sides run on clk_sys; depth is a power of two.
 */
`default_nettype none

module rlwg_fifo #(
    parameter int W = 40,
    parameter int D = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [0:D-1];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end

endmodule : rlwg_fifo

`default_nettype wire

// File: rtl/rlwg_lane.sv
/*
 * Raw lane datapath: fabric words through a transmit FIFO, the width
 * gearing serializer and the transmit deskew delay onto the medium
 * parallel bus; medium words through the gearing deserializer and a
 * receive FIFO back to the fabric.
 * Assumes the fabric side runs on clk_sys; the medium parallel clock
 * arrives on a pin and is sampled here; the far end changes its
 * receive data away from the medium clock's rising edge.
 */
`include "rlwg_defines.svh"

`default_nettype none

module rlwg_lane
    import rlwg_pkg::*;
#(
    parameter int BUS_W = `RLWG_BUS_W,
    parameter int PMA_W = `RLWG_PMA_W,
    parameter int FIFO_DEPTH = `RLWG_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // static configuration
    input wire rlwg_mode_t mode,
    input wire logic [1:0] deskew_dly,
    // fabric transmit stream
    input wire logic [BUS_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // fabric receive stream
    output logic [BUS_W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // medium parallel port
    input wire logic pma_clk,
    output logic [PMA_W-1:0] pma_txd,
    input wire logic [PMA_W-1:0] pma_rxd,
    // status pulses
    output logic tx_underrun,
    output logic rx_overflow
);

    // mode geometry: {slice width, slice stride, slice count}
    function automatic logic [12:0] geom(rlwg_mode_t m);
        logic [12:0] g;
        g = {5'd20, 5'd20, 3'd1};
        case (m)
            RLWG_M1A: g = {5'd20, 5'd20, 3'd1};
            RLWG_M1B: g = {5'd20, 5'd20, 3'd2};
            RLWG_M2A: g = {5'd10, 5'd10, 3'd1};
            RLWG_M2B: g = {5'd10, 5'd10, 3'd2};
            RLWG_M2C: g = {5'd10, 5'd10, 3'd2};
            RLWG_M2D: g = {5'd10, 5'd10, 3'd4};
            RLWG_M3A: g = {5'd5, 5'd5, 3'd2};
            RLWG_M3B: g = {5'd5, 5'd5, 3'd4};
            RLWG_M4A: g = {5'd16, 5'd16, 3'd1};
            RLWG_M4B: g = {5'd16, 5'd20, 3'd2};
            RLWG_M5A: g = {5'd8, 5'd8, 3'd1};
            RLWG_M5B: g = {5'd8, 5'd10, 3'd2};
            default: g = {5'd20, 5'd20, 3'd1};
        endcase
        return g;
    endfunction : geom

    // decoded geometry of the selected mode
    wire [12:0] mode_geom = geom(mode);
    wire [4:0] sl_w = mode_geom[12:8];
    wire [4:0] sl_str = mode_geom[7:3];
    wire [2:0] sl_n = mode_geom[2:0];

    // low sl_w bits set; the 21st bit absorbs the full-width case
    wire [PMA_W:0] wm_full = ((PMA_W+1)'(1) << sl_w) - (PMA_W+1)'(1);
    wire [PMA_W-1:0] wmask = wm_full[PMA_W-1:0];

    // medium clock sampled into the system domain
    logic pma_sync1;
    logic pma_sync2;
    logic pma_prev;
    wire pma_rise = pma_sync2 && !pma_prev;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pma_sync1 <= 1'b0;
            pma_sync2 <= 1'b0;
            pma_prev <= 1'b0;
        end else begin
            pma_sync1 <= pma_clk;
            pma_sync2 <= pma_sync1;
            pma_prev <= pma_sync2;
        end
    end

    // receive data pins pass the same two-stage delay as the clock
    logic [PMA_W-1:0] rxd_s1;
    logic [PMA_W-1:0] rxd_s2;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rxd_s1 <= '0;
            rxd_s2 <= '0;
        end else begin
            rxd_s1 <= pma_rxd;
            rxd_s2 <= rxd_s1;
        end
    end

    // a mode change restarts both slice counters on a word boundary
    rlwg_mode_t mode_q;
    wire mode_chg = (mode != mode_q);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= RLWG_M1A;
        end else begin
            mode_q <= mode;
        end
    end

    // transmit FIFO: the only storage ahead of the serializer
    logic txf_valid;
    logic [BUS_W-1:0] txf_data;
    logic [1:0] tx_idx;
    wire tx_pop = pma_rise && !mode_chg && (tx_idx == 2'd0) && txf_valid;

    // absorbs fabric bursts; sustained rate is the user's duty
    rlwg_fifo #(
        .W(BUS_W),
        .D(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(txf_valid),
        .out_ready(tx_pop),
        .out_data(txf_data)
    );

    // serializer: the first slice comes straight from the FIFO head
    logic [BUS_W-1:0] tx_word;
    wire [BUS_W-1:0] tx_src = (tx_idx == 2'd0) ? txf_data : tx_word;
    wire [5:0] tx_off = 6'(tx_idx) * 6'(sl_str);
    wire [BUS_W-1:0] tx_shift = tx_src >> tx_off;
    // upper bus bits outside the slice never reach the medium
    wire [PMA_W-1:0] tx_slice = tx_shift[PMA_W-1:0] & wmask;
    wire tx_empty_slot = (tx_idx == 2'd0) && !txf_valid;
    wire [PMA_W-1:0] tx_launch_d = tx_empty_slot ? '0 : tx_slice;
    wire tx_last = (3'(tx_idx) + 3'd1) >= sl_n;
    wire [1:0] next_tx_idx = tx_last ? 2'd0 : tx_idx + 2'd1;

    logic [PMA_W-1:0] tx_launch;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_idx <= 2'd0;
            tx_word <= '0;
            tx_launch <= '0;
        end else if (mode_chg) begin
            tx_idx <= 2'd0;
        end else if (pma_rise && !tx_empty_slot) begin
            tx_idx <= next_tx_idx;
            tx_launch <= tx_launch_d;
            if (tx_idx == 2'd0) begin
                tx_word <= txf_data;
            end
        end else if (pma_rise) begin
            tx_launch <= '0;
        end
    end

    // idle slots send zeros rather than repeat stale data
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_underrun <= 1'b0;
        end else begin
            tx_underrun <= pma_rise && !mode_chg && tx_empty_slot;
        end
    end

    // transmit deskew: whole medium cycles of extra delay
    logic [PMA_W-1:0] dpipe [0:`RLWG_DSK_STAGES-1];
    wire [1:0] dsk_tap = deskew_dly - 2'd1;
    wire [PMA_W-1:0] dsk_sel = (deskew_dly == 2'd0) ? tx_launch : dpipe[dsk_tap];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `RLWG_DSK_STAGES; i++) begin
                dpipe[i] <= '0;
            end
        end else if (pma_rise) begin
            dpipe[0] <= tx_launch;
            for (int i = 1; i < `RLWG_DSK_STAGES; i++) begin
                dpipe[i] <= dpipe[i-1];
            end
        end
    end

    // bit 0 of the medium word is the serializer's first bit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pma_txd <= '0;
        end else if (pma_rise) begin
            pma_txd <= dsk_sel;
        end
    end

    // deserializer: same slice geometry as transmit
    logic [1:0] rx_idx;
    logic [BUS_W-1:0] rx_asm;
    wire [5:0] rx_off = 6'(rx_idx) * 6'(sl_str);
    wire [BUS_W-1:0] rx_slice = {{(BUS_W-PMA_W){1'b0}}, rxd_s2 & wmask};
    wire [BUS_W-1:0] rx_clr = {{(BUS_W-PMA_W){1'b0}}, wmask} << rx_off;
    // a new word starts from zero, so unused bits read as zero
    wire [BUS_W-1:0] rx_base = (rx_idx == 2'd0) ? '0 : (rx_asm & ~rx_clr);
    wire [BUS_W-1:0] next_rx_asm = rx_base | (rx_slice << rx_off);
    wire rx_last = (3'(rx_idx) + 3'd1) >= sl_n;
    wire [1:0] next_rx_idx = rx_last ? 2'd0 : rx_idx + 2'd1;
    wire rxf_push = pma_rise && !mode_chg && rx_last;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_idx <= 2'd0;
            rx_asm <= '0;
        end else if (mode_chg) begin
            rx_idx <= 2'd0;
        end else if (pma_rise) begin
            rx_idx <= next_rx_idx;
            rx_asm <= next_rx_asm;
        end
    end

    // receive FIFO
    logic rxf_ready;

    rlwg_fifo #(
        .W(BUS_W),
        .D(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(rxf_push),
        .in_ready(rxf_ready),
        .in_data(next_rx_asm),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // the medium cannot be stalled, so a full FIFO loses the word
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_overflow <= 1'b0;
        end else begin
            rx_overflow <= rxf_push && !rxf_ready;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_tx_pop_slot: assert property (
        tx_pop |-> pma_rise && tx_idx == 2'd0 && txf_valid
    ) else $error("tx word taken outside the first slot");

    chk_tx_idx_range: assert property (
        3'(tx_idx) < sl_n && 3'(rx_idx) < sl_n
    ) else $error("slice counter beyond slice count");

    chk_tx_first_low: assert property (
        tx_pop && !$changed(mode) |=> tx_launch == ($past(txf_data[PMA_W-1:0]) & wmask)
    ) else $error("first launched slice is not the low bits");

    chk_tx_upper_zero: assert property (
        (tx_launch & ~wmask) == '0
    ) else $error("bits above slice width reach medium");

    chk_deskew_bypass: assert property (
        pma_rise && deskew_dly == 2'd0 |=> pma_txd == $past(tx_launch)
    ) else $error("zero deskew adds delay");

    chk_single_slot: assert property (
        sl_n == 3'd1 && pma_rise && !mode_chg && txf_valid |-> tx_pop
    ) else $error("one-slice mode skips a medium cycle");

    chk_rx_push_last: assert property (
        rxf_push |-> 3'(rx_idx) == sl_n - 3'd1
    ) else $error("rx word pushed before last slice");

    chk_rx_first_low: assert property (
        pma_rise && rx_idx == 2'd0 |->
            next_rx_asm == {{(BUS_W-PMA_W){1'b0}}, rxd_s2 & wmask}
    ) else $error("first received slice not in low bits");

    chk_rx_upper_zero: assert property (
        rxf_push && sl_n == 3'd1 |-> next_rx_asm[BUS_W-1:PMA_W] == '0
    ) else $error("unused rx bits not zero");

    chk_tx_next_slice: assert property (
        pma_rise && !mode_chg && tx_idx == 2'd1 && sl_n == 3'd4 |=> tx_idx == 2'd2
    ) else $error("four-slice order broken");

    chk_txd_hold: assert property (
        !pma_rise |=> $stable(pma_txd)
    ) else $error("medium word changed between medium edges");

    chk_rx_hold: assert property (
        !pma_rise && !mode_chg |=> $stable(rx_asm) && $stable(rx_idx)
    ) else $error("rx assembly moved without a medium edge");

    chk_mode_restart: assert property (
        mode_chg |=> tx_idx == 2'd0 && rx_idx == 2'd0
    ) else $error("mode change left a slice counter running");

    chk_idle_zero: assert property (
        tx_underrun |-> tx_launch == '0
    ) else $error("empty slot launched nonzero data");

    chk_deskew_one: assert property (
        pma_rise && deskew_dly == 2'd1 |=> pma_txd == $past(dpipe[0])
    ) else $error("one-cycle deskew tap wrong");

    chk_ovf_cause: assert property (
        rx_overflow |-> $past(rxf_push) && !$past(rxf_ready)
    ) else $error("overflow pulse without a dropped word");

    cov_four_slices: cover property (
        sl_n == 3'd4 && pma_rise && tx_idx == 2'd3
    );

    cov_rx_word: cover property (
        rxf_push && rxf_ready && sl_n == 3'd2
    );

    cov_rx_overflow: cover property (
        rx_overflow
    );

    cov_tx_underrun: cover property (
        tx_underrun
    );

endmodule : rlwg_lane

`default_nettype wire

// File: testbench/rlwg_medium.sv
/*
 * Medium side model: makes the parallel clock during frames, sends queued
 * receive slices and records every transmit word seen at a rising edge.
 * Assumes the bench fills rxq and sets cycles to start a frame.
 */
`default_nettype none

module rlwg_medium (
    // medium parallel port
    output var logic pma_clk,
    output var logic [19:0] pma_rxd,
    input wire logic [19:0] pma_txd
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [19:0] rxq[$];
    logic [19:0] txq[$];
    int cycles = 0;

    initial begin
        pma_clk = 1'b0;
        pma_rxd = 20'h00000;
    end

    // clock stands still outside frames; odd offset keeps phase unrelated
    always begin
        wait (cycles > 0);
        #3;
        while (cycles > 0) begin
            // slices change on the falling side, low slice first
            pma_rxd = (rxq.size() > 0) ? rxq.pop_front() : ~pma_rxd;
            #40;
            pma_clk = 1'b1;
            txq.push_back(pma_txd);
            #40;
            pma_clk = 1'b0;
            cycles--;
        end
    end
endmodule : rlwg_medium

`default_nettype wire

// File: testbench/rlwg_lane_tb.sv
/*
 * Self-checking bench of the raw lane: every gearing mode in turn, random
 * words both ways, compared with a queue model of the slice geometry.
 * Assumes rlwg_pkg is compiled first and the medium model beside it.
 */
`default_nettype none

module rlwg_lane_tb
    import rlwg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    rlwg_mode_t mode = RLWG_M1A;
    logic [1:0] deskew_dly = 2'h0;
    logic [39:0] tx_data = 40'h0;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic tx_ready, rx_valid, pma_clk;
    logic tx_underrun, rx_overflow;
    logic rx_hold = 1'b0;
    logic [39:0] rx_data;
    logic [19:0] pma_txd, pma_rxd;
    int fail_count = 0;
    int cmp_count = 0;
    int wd[12] = '{20, 20, 10, 10, 10, 10, 5, 5, 16, 16, 8, 8};
    int sd[12] = '{20, 20, 10, 10, 10, 10, 5, 5, 16, 20, 8, 10};
    int nd[12] = '{1, 2, 1, 2, 2, 4, 2, 4, 1, 2, 1, 2};
    logic [39:0] rx_exp[$];
    logic [19:0] tx_exp[$];

    always #5 clk_sys = ~clk_sys;

    rlwg_lane dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .mode(mode), .deskew_dly(deskew_dly),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .pma_clk(pma_clk), .pma_txd(pma_txd), .pma_rxd(pma_rxd),
        .tx_underrun(tx_underrun), .rx_overflow(rx_overflow)
    );

    rlwg_medium med_u (.pma_clk(pma_clk), .pma_rxd(pma_rxd), .pma_txd(pma_txd));

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // receive side stalls at random
    always @(negedge clk_sys) rx_ready <= !rx_hold && (($urandom % 4) != 0);

    always @(posedge clk_sys) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1 && rx_exp.size() > 0) begin
            check("rx_data", rx_data, rx_exp.pop_front());
        end
    end

    initial begin
        logic [39:0] w;
        logic [19:0] s;
        int m, k, i, got, lim, first, n, und, ovf;
        void'($urandom(32'hd9a50b32));
        for (m = 0; m < 12; m++) begin
            n = (m == 0) ? 40 : 5;
            @(negedge clk_sys);
            rst_b = 1'b0;
            mode = rlwg_mode_t'(m);
            // each deskew tap is used three times over the run
            deskew_dly = 2'(m);
            repeat (5) @(negedge clk_sys);
            rst_b = 1'b1;
            med_u.txq.delete();
            // words queue up while the medium clock stands still
            got = 0;
            lim = 0;
            w = {8'($urandom), $urandom} | 40'h1;
            while (got < n && lim < 60) begin
                @(negedge clk_sys);
                lim++;
                tx_data = w;
                tx_valid = 1'b1;
                if (tx_ready === 1'b1) begin
                    for (k = 0; k < nd[m]; k++) begin
                        tx_exp.push_back(20'((w >> (k * sd[m])) & ((40'h1 << wd[m]) - 1)));
                    end
                    got++;
                    w = {8'($urandom), $urandom};
                end
            end
            @(negedge clk_sys);
            tx_valid = 1'b0;
            check("tx_taken", 40'(got), (m == 0) ? 40'd32 : 40'(n));
            for (i = 0; i < 5; i++) begin
                w = 40'h0;
                for (k = 0; k < nd[m]; k++) begin
                    s = 20'($urandom);
                    med_u.rxq.push_back(s);
                    w = w | ((40'(s) & ((40'h1 << wd[m]) - 1)) << (k * sd[m]));
                end
                rx_exp.push_back(w);
            end
            // margin covers sync, launch and the largest deskew
            // mode 0 stalls the receive side: 42 words into 32 slots drops 10
            rx_hold = (m == 0);
            und = 0;
            ovf = 0;
            med_u.cycles = got * nd[m] + 10;
            lim = 0;
            while ((med_u.cycles > 0 || rx_exp.size() > 0) && lim < 5000) begin
                @(posedge clk_sys);
                lim++;
                if (tx_underrun === 1'b1) begin
                    und++;
                end
                if (rx_overflow === 1'b1) begin
                    ovf++;
                end
                if (med_u.cycles == 0) begin
                    rx_hold = 1'b0;
                end
            end
            if (lim >= 5000) begin
                fail_count++;
                break;
            end
            // the 10 margin slots find the transmit FIFO drained
            check("tx_underrun", 40'(und), 40'd10);
            check("rx_overflow", 40'(ovf), (m == 0) ? 40'd10 : 40'd0);
            first = 0;
            while (first < med_u.txq.size() && med_u.txq[first] === 20'h0) first++;
            for (i = 0; i < tx_exp.size(); i++) begin
                s = (first + i < med_u.txq.size()) ? med_u.txq[first + i] : 20'hfffff;
                check("pma_txd", 40'(s), 40'(tx_exp[i]));
            end
            tx_exp.delete();
            med_u.rxq.delete();
        end
        summarize();
    end
endmodule : rlwg_lane_tb

`default_nettype wire
